// ---- include/hbd_pkg.sv ----
package hbd_pkg;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_FIFO = 12'h008;
  localparam logic [11:0] OFF_COUNT = 12'h00C;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_NEGATE_BIT = 2;
  localparam int CTRL_BURST_BIT = 3;
  localparam int CTRL_DMA_EN_BIT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int END_DELAY_NS = 30;
  localparam int CLK_NS = 10;
  localparam int END_DELAY_CYC = (END_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int BURST_WORDS = 8;
  localparam int PREP_CYC = 2;
  typedef enum logic [1:0] {HBD_MODE1, HBD_MODE2, HBD_MODE3} hbd_mode_e;
  typedef enum logic [1:0] {HBD_IDLE, HBD_WAIT, HBD_DONE} hbd_acc_e;
endpackage : hbd_pkg

// ---- logic/hbd_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module hbd_fifo
  import hbd_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } hbd_fifo_s;
  hbd_fifo_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr, do_rd;

  assign level = st.wp - st.rp;
  assign wr_ready = level != (AW+1)'(DEPTH);
  assign rd_valid = level != '0;
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;
  assign rd_data = mem[st.rp[AW-1:0]];

  always_comb begin
    next_st = st;
    if (do_wr) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (do_rd) begin
      next_st.rp = st.rp + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[st.wp[AW-1:0]] <= wr_data;
    end
  end
endmodule : hbd_fifo
`default_nettype wire

// ---- logic/hbd_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module hbd_port
  import hbd_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host cpu access
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_we_n,
  input wire logic [3:0] byte_lane_enable_n,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_ready_o,
  output logic host_ready_oe_n,
  // dma handshake
  output logic dma_request_out,
  input wire logic dma_transfer_ack_in,
  input wire logic dma_request_ack_in,
  input wire logic dma_grant_ack_in,
  input wire logic terminal_count_in_n,
  // display-list drain
  output logic dl_valid,
  input wire logic dl_ready,
  output logic [31:0] dl_data
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] count;
    hbd_acc_e acc;
    logic [1:0] prep;
    logic acc_wr;
    logic [31:0] rdata;
    logic ready_drv;
    logic ready_lvl;
    logic [3:0] lanes;
    logic [2:0] beat;
    logic [1:0] end_cnt;
    logic ending;
    logic req;
    logic [31:0] prdata;
  } hbd_s;
  hbd_s st, next_st;

  logic fifo_wr_valid, fifo_wr_ready;
  logic [31:0] fifo_wr_data;
  logic [$clog2(DEPTH):0] fifo_level;
  hbd_mode_e mode;
  logic negate_opt, burst, dma_en, room, last_ack;
  logic apb_acc, host_start;

  assign mode = hbd_mode_e'(st.ctrl[CTRL_MODE_LSB +: 2]);
  assign negate_opt = st.ctrl[CTRL_NEGATE_BIT];
  assign burst = st.ctrl[CTRL_BURST_BIT];
  assign dma_en = st.ctrl[CTRL_DMA_EN_BIT];
  assign room = fifo_level <= ($clog2(DEPTH)+1)'(DEPTH - BURST_WORDS);
  assign apb_acc = psel && penable;
  assign host_start = !host_cs_n && (!host_rd_n || !host_we_n) && st.acc == HBD_IDLE;
  // mode three: terminal when grant and count both active
  assign last_ack = (mode == HBD_MODE3) ? (dma_grant_ack_in && !terminal_count_in_n) :
    dma_request_ack_in;

  hbd_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(fifo_wr_data),
    .rd_valid(dl_valid),
    .rd_ready(dl_ready),
    .rd_data(dl_data),
    .level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fifo feed: dma strobe, apb write to fifo address, or host static write
  always_comb begin
    fifo_wr_valid = 1'b0;
    fifo_wr_data = host_wdata;
    if (dma_en && mode == HBD_MODE2 && dma_transfer_ack_in) begin
      fifo_wr_valid = 1'b1;
    end else if (apb_acc && pwrite && paddr == OFF_FIFO) begin
      fifo_wr_valid = 1'b1;
      fifo_wr_data = pwdata;
    end else if (st.acc == HBD_DONE && st.acc_wr) begin
      fifo_wr_valid = 1'b1;
      fifo_wr_data = host_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    // apb registers
    if (apb_acc && pwrite) begin
      if (paddr == OFF_CTRL) begin
        next_st.ctrl = pwdata;
      end else if (paddr == OFF_COUNT) begin
        next_st.count = pwdata[15:0];
      end
    end
    // read data loaded in setup so it stands through the access phase
    if (psel && !penable && !pwrite) begin
      if (paddr == OFF_CTRL) begin
        next_st.prdata = st.ctrl;
      end else if (paddr == OFF_STATUS) begin
        next_st.prdata = {20'h0, st.req, st.ending, st.acc, 8'(fifo_level)};
      end else if (paddr == OFF_COUNT) begin
        next_st.prdata = {16'h0, st.count};
      end else begin
        next_st.prdata = 32'h0000_0000;
      end
    end
    // host static access sequencer
    case (st.acc)
      HBD_IDLE: begin
        next_st.ready_drv = 1'b0;
        if (host_start) begin
          next_st.acc = HBD_WAIT;
          next_st.prep = 2'(PREP_CYC);
          next_st.acc_wr = !host_we_n;
          // byte lanes only on writes in mode three
          next_st.lanes = (mode == HBD_MODE3 && host_we_n) ? 4'h0 : byte_lane_enable_n;
          next_st.ready_drv = 1'b1;
          next_st.ready_lvl = (mode == HBD_MODE1) ? 1'b0 : 1'b1;
        end
      end
      HBD_WAIT: begin
        if (st.prep != 2'h0) begin
          next_st.prep = st.prep - 2'h1;
        end else if (!st.acc_wr || fifo_wr_ready) begin
          next_st.acc = HBD_DONE;
          next_st.rdata = {16'h0, st.count};
          next_st.ready_lvl = (mode == HBD_MODE1) ? 1'b1 : 1'b0;
        end
      end
      default: begin
        next_st.acc = HBD_IDLE;
        // mode three drives ready then floats
        next_st.ready_drv = 1'b0;
        next_st.ready_lvl = (mode == HBD_MODE1) ? 1'b0 : 1'b1;
      end
    endcase
    // dma request and termination
    if (!dma_en) begin
      next_st.req = 1'b0;
      next_st.ending = 1'b0;
      next_st.beat = 3'h0;
    end else if (st.ending) begin
      next_st.end_cnt = st.end_cnt + 2'h1;
      if (st.end_cnt == 2'(END_DELAY_CYC)) begin
        next_st.req = 1'b0;
        next_st.ending = 1'b0;
        next_st.ctrl[CTRL_DMA_EN_BIT] = 1'b0;
      end
    end else if (last_ack && (mode == HBD_MODE3 || dma_transfer_ack_in || st.acc == HBD_DONE)) begin
      if (mode == HBD_MODE3) begin
        next_st.req = 1'b0;
        next_st.ctrl[CTRL_DMA_EN_BIT] = 1'b0;
      end else begin
        next_st.ending = 1'b1;
        next_st.end_cnt = 2'h1;
      end
    end else if (mode == HBD_MODE2) begin
      if (dma_transfer_ack_in) begin
        next_st.beat = (!burst || st.beat == 3'(BURST_WORDS - 1)) ? 3'h0 : st.beat + 3'h1;
      end
      // single-address: level follows fifo room
      next_st.req = room;
    end else begin
      next_st.req = negate_opt ? (st.acc != HBD_WAIT) : 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.ready_lvl <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign host_rdata = st.rdata;
  assign host_ready_o = st.ready_lvl;
  assign host_ready_oe_n = !(st.ready_drv || mode != HBD_MODE3);
  assign dma_request_out = st.req;

  ////////////////////////////////////////////////////////////////////////////
  property p_wait_mode1;
    @(posedge pclk) disable iff (!presetn)
      (host_start && mode == HBD_MODE1) |=> !host_ready_o [*2];
  endproperty
  a_wait_mode1: assert property (p_wait_mode1) else $error("mode one wait not held");
  property p_notready_mode2;
    @(posedge pclk) disable iff (!presetn)
      (host_start && mode == HBD_MODE2) |=> host_ready_o [*2];
  endproperty
  a_notready_mode2: assert property (p_notready_mode2) else $error("mode two ready early");
  property p_release_mode3;
    @(posedge pclk) disable iff (!presetn)
      (st.acc == HBD_DONE && mode == HBD_MODE3) |-> !host_ready_o ##1 host_ready_oe_n;
  endproperty
  a_release_mode3: assert property (p_release_mode3) else $error("mode three not released");
  property p_lanes_read;
    @(posedge pclk) disable iff (!presetn)
      (host_start && mode == HBD_MODE3 && host_we_n) |=> st.lanes == 4'h0;
  endproperty
  a_lanes_read: assert property (p_lanes_read) else $error("lanes used on read");
  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      (dma_en && mode == HBD_MODE2 && dma_transfer_ack_in) |-> fifo_wr_valid;
  endproperty
  a_capture: assert property (p_capture) else $error("ack data not captured");
  property p_drop_full;
    @(posedge pclk) disable iff (!presetn)
      (dma_en && mode == HBD_MODE2 && !room && !st.ending && !last_ack) |=> !dma_request_out;
  endproperty
  a_drop_full: assert property (p_drop_full) else $error("request held while full");
  property p_negate_opt;
    @(posedge pclk) disable iff (!presetn)
      (dma_en && mode == HBD_MODE1 && negate_opt && st.acc == HBD_WAIT && !st.ending && !last_ack)
        |=> !dma_request_out;
  endproperty
  a_negate_opt: assert property (p_negate_opt) else $error("request not dropped");
  property p_end3;
    @(posedge pclk) disable iff (!presetn)
      (st.ending && st.end_cnt == 2'h1 && dma_en) |=> ##2 !dma_request_out;
  endproperty
  a_end3: assert property (p_end3) else $error("end negate timing wrong");
  property p_tc;
    @(posedge pclk) disable iff (!presetn)
      (dma_en && mode == HBD_MODE3 && dma_grant_ack_in && !terminal_count_in_n) |=> !dma_request_out;
  endproperty
  a_tc: assert property (p_tc) else $error("mode three end missed");
  c_host: cover property (@(posedge pclk) st.acc == HBD_DONE);
  c_dma: cover property (@(posedge pclk) mode == HBD_MODE2 && dma_transfer_ack_in);
  c_burst: cover property (@(posedge pclk) st.beat == 3'h7);
  c_end: cover property (@(posedge pclk) st.ending);
endmodule : hbd_port
`default_nettype wire

// ---- dv/hbd_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module hbd_host_model (
  input wire logic pclk,
  input wire logic dma_request_out,
  input wire logic host_ready_o,
  input wire logic host_ready_oe_n,
  output logic host_cs_n,
  output logic host_rd_n,
  output logic host_we_n,
  output logic [3:0] byte_lane_enable_n,
  output logic [31:0] host_wdata,
  output logic dma_transfer_ack_in,
  output logic dma_request_ack_in,
  output logic dma_grant_ack_in,
  output logic terminal_count_in_n
);
  initial begin
    {host_cs_n, host_rd_n, host_we_n, terminal_count_in_n} = 4'hF;
    {dma_transfer_ack_in, dma_request_ack_in, dma_grant_ack_in} = 3'h0;
    byte_lane_enable_n = 4'hF;
    host_wdata = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////
  // cpu access held until the ready level is seen at an edge
  task automatic cpu_access(input logic w, input logic [31:0] d, input logic act, output int n);
    n = 0;
    host_cs_n <= 1'b0;
    host_rd_n <= w;
    host_we_n <= ~w;
    byte_lane_enable_n <= w ? 4'h0 : d[3:0];
    host_wdata <= d;
    do begin
      @(posedge pclk);
      n++;
    end while ((n < 2 || !(host_ready_oe_n === 1'b0 && host_ready_o === act)) && n < 20);
    {host_cs_n, host_rd_n, host_we_n} <= 3'h7;
    host_wdata <= ~d;
  endtask : cpu_access
  // bus handed back for two cycles between beats
  task automatic dma_beat(input logic [31:0] d, input logic last);
    repeat (2) @(posedge pclk);
    while (dma_request_out !== 1'b1) @(posedge pclk);
    dma_transfer_ack_in <= 1'b1;
    dma_request_ack_in <= last;
    host_wdata <= d;
    @(posedge pclk);
    {dma_transfer_ack_in, dma_request_ack_in} <= 2'h0;
    host_wdata <= ~d;
  endtask : dma_beat
  task automatic term3(input logic tc);
    @(posedge pclk);
    dma_grant_ack_in <= 1'b1;
    terminal_count_in_n <= ~tc;
    @(posedge pclk);
    dma_grant_ack_in <= 1'b0;
    terminal_count_in_n <= 1'b1;
  endtask : term3
endmodule : hbd_host_model
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  import hbd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic dl_ready = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd, seed = 32'h0000_284D;
  logic [31:0] prdata, host_rdata, dl_data, host_wdata;
  logic pready, pslverr, host_cs_n, host_rd_n, host_we_n, host_ready_o, host_ready_oe_n, dma_request_out;
  logic dma_transfer_ack_in, dma_request_ack_in, dma_grant_ack_in, terminal_count_in_n, dl_valid;
  logic [3:0] byte_lane_enable_n;
  logic [31:0] expq[$];
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  always #5 pclk = ~pclk;
  hbd_port #(.DEPTH(8)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .host_cs_n, .host_rd_n, .host_we_n, .byte_lane_enable_n, .host_wdata, .host_rdata,
    .host_ready_o, .host_ready_oe_n, .dma_request_out, .dma_transfer_ack_in, .dma_request_ack_in,
    .dma_grant_ack_in, .terminal_count_in_n, .dl_valid, .dl_ready, .dl_data);
  hbd_host_model host (.pclk, .dma_request_out, .host_ready_o, .host_ready_oe_n, .host_cs_n, .host_rd_n,
    .host_we_n, .byte_lane_enable_n, .host_wdata, .dma_transfer_ack_in, .dma_request_ack_in,
    .dma_grant_ack_in, .terminal_count_in_n);
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // drained words in order of arrival
  always @(posedge pclk) begin
    if (presetn && dl_valid === 1'b1 && dl_ready === 1'b1) begin
      if (expq.size() == 0) chk({31'h0, dl_valid}, 32'h0);
      else chk(dl_data, expq.pop_front());
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b1, OFF_CTRL, 32'h0000_0006);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0006);
    apb(1'b0, 12'hFF0, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, OFF_CTRL, 32'(m));
      for (int i = 0; i < 3; i++) begin
        seed = xs(seed);
        if (m == 2 || seed[0]) expq.push_back(seed);
        host.cpu_access(m == 2 || seed[0], seed, m == 0, n);
        chk(n, PREP_CYC + 3);
        @(negedge pclk);
        if (m == 2) chk(host_ready_oe_n, 32'h1);
        else chk(host_ready_o, 32'(m != 0));
        @(posedge pclk);
      end
    end
    $display("test host access done");
    apb(1'b1, OFF_CTRL, 32'h0000_0011);
    seed = xs(seed);
    expq.push_back(seed);
    host.dma_beat(seed, 1'b1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(dma_request_out, 32'h1);
    @(negedge pclk);
    chk(dma_request_out, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h0000_0019);
    dl_ready <= 1'b0;
    fork
      for (int i = 0; i < BURST_WORDS; i++) begin
        seed = xs(seed);
        expq.push_back(seed);
        host.dma_beat(seed, i == BURST_WORDS - 1);
      end
      begin
        repeat (30) @(posedge pclk);
        @(negedge pclk);
        chk(dma_request_out, 32'h0);
        repeat (10) @(posedge pclk);
        dl_ready <= 1'b1;
      end
    join
    repeat (20) @(posedge pclk);
    chk(expq.size(), 32'h0);
    $display("test dma single address done");
    apb(1'b1, OFF_CTRL, 32'h0000_0012);
    repeat (5) @(posedge pclk);
    host.term3(1'b0);
    repeat (3) @(negedge pclk);
    chk(dma_request_out, 32'h1);
    host.term3(1'b1);
    repeat (3) @(negedge pclk);
    chk(dma_request_out, 32'h0);
    $display("test dma end done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
